//--- shared/bfp_pkg.sv
/*
 * Constants for the buck fault protection sequencer: clock rate, switching
 * period, duty limit, protection and soft-start timing, counter widths.
 * Assumes a 200 MHz system clock and a 300 kHz switching rate.
 */
package bfp_pkg;
    // clock and switching rate
    localparam int CLK_HZ = 200_000_000;
    localparam int FSW_HZ = 300_000;
    localparam int CLK_PER_US = CLK_HZ / 1_000_000;
    localparam int SAW_W = 10;
    localparam int SAW_PERIOD = CLK_HZ / FSW_HZ;
    // duty limit
    localparam int DUTY_MAX_PCT = 80;
    localparam int DUTY_MAX_CNT = SAW_PERIOD * DUTY_MAX_PCT / 100;
    // fault off wait in switching cycles
    localparam int FAULT_WAIT_SW = 2048;
    localparam int SW_CNT_W = 11;
    // typical hiccup repetition, informative only
    localparam int HICCUP_PERIOD_US = 13_600;
    // soft-start ramp length, rounded down to cycles
    localparam int SS_TIME_US = 5_100;
    localparam int SS_CYCLES = SS_TIME_US * CLK_PER_US;
    // threshold setting phase, least time taken, rounded up
    localparam int OCSET_MIN_US = 5_500;
    localparam int OCSET_MAX_US = 6_500;
    localparam int OCSET_CYCLES = OCSET_MIN_US * CLK_PER_US;
    localparam int TMR_W = 21;
    // soft-start reference word
    localparam int REF_W = 8;
    localparam logic [REF_W-1:0] REF_FULL = 8'hFF;
    localparam logic [REF_W-1:0] REF_ZERO = 8'h00;
    localparam int STEP_W = 12;
    // synchroniser depth is two flops for each comparator flag
    localparam int FLAG_N = 3;
    localparam int FLAG_SUP = 0;
    localparam int FLAG_LOW = 1;
    localparam int FLAG_HIGH = 2;

    typedef enum logic [2:0] {
        BFP_LOCKOUT,
        BFP_OCSET,
        BFP_SOFTSTART,
        BFP_RUN,
        BFP_FAULT_OFF
    } bfp_state_t;
endpackage

//--- src/bfp_pwm.sv
/*
 * Sawtooth counter and PWM comparator with duty clamp.
 * Assumes the error level word is on the same clock as the counter.
 */
`timescale 1ns/1ps
module bfp_pwm import bfp_pkg::*; #(
    parameter int PERIOD = SAW_PERIOD,
    parameter int DUTY_MAX = DUTY_MAX_CNT
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // error level
    input wire logic [SAW_W-1:0] level_i,
    // pwm and switching tick
    output logic pwm_o,
    output logic tick_o
);
    logic [SAW_W-1:0] cnt_ff;

    // saturation never pushes duty past the limit
    function automatic logic [SAW_W-1:0] bfp_clamp(input logic [SAW_W-1:0] lvl);
        logic [SAW_W-1:0] lim;
        lim = SAW_W'(DUTY_MAX);
        bfp_clamp = (lvl > lim) ? lim : lvl;
    endfunction

    // sawtooth ramp, one wrap per switching cycle
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_ff <= '0;
            tick_o <= 1'b0;
        end else if (cnt_ff == SAW_W'(PERIOD - 1)) begin
            cnt_ff <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + SAW_W'(1);
            tick_o <= 1'b0;
        end
    end

    // high while ramp is below the error level
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwm_o <= 1'b0;
        end else begin
            pwm_o <= (cnt_ff < bfp_clamp(level_i));
        end
    end

    property p_duty;
        @(posedge clk_i) disable iff (!nrst_i)
        ($past(cnt_ff) >= SAW_W'(DUTY_MAX)) |-> !pwm_o;
    endproperty
    AST_DUTY_LIMIT: assert property (p_duty) else $error("pwm high past duty limit");
endmodule

//--- src/bfp_sequencer.sv
/*
 * Protection and restart sequencer of a single-phase buck controller:
 * supply lockout, threshold setting wait, soft-start ramp, low output
 * hiccup, high output override and the gate enables.
 * Assumes comparator flags arrive asynchronously from analog circuits and
 * the error level word is produced on clk_i.
 */
`timescale 1ns/1ps
module bfp_sequencer import bfp_pkg::*; #(
    parameter int SS_CYCLES_P = SS_CYCLES,
    parameter int OCSET_CYCLES_P = OCSET_CYCLES,
    parameter int FAULT_WAIT_P = FAULT_WAIT_SW
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // comparator flags, asynchronous
    input wire logic supply_ok_i,
    input wire logic low_output_fault_i,
    input wire logic high_output_fault_i,
    // error amplifier level
    input wire logic [SAW_W-1:0] error_amp_i,
    // gate enables
    output logic high_side_gate_o,
    output logic low_side_gate_o,
    // soft-start reference and status
    output logic [REF_W-1:0] ss_ref_o,
    output logic soft_start_o,
    output logic fault_off_o
);
    localparam int SS_STEP_RAW = SS_CYCLES_P / int'(REF_FULL);
    localparam int SS_STEP = (SS_STEP_RAW < 1) ? 1 : SS_STEP_RAW;

    bfp_state_t state_ff;
    logic [FLAG_N-1:0] sync1_ff;
    logic [FLAG_N-1:0] sync2_ff;
    logic [TMR_W-1:0] tmr_ff;
    logic [SW_CNT_W-1:0] sw_cnt_ff;
    logic [STEP_W-1:0] step_ff;
    logic hs_seen_ff;
    logic pwm;
    logic sw_tick;
    logic sup_s;
    logic uv_s;
    logic ov_s;
    logic ss_done;
    logic guard_on;
    logic nxt_hs;
    logic nxt_ls;

    // two-flop synchronisers; only the second stage is looked at
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {high_output_fault_i, low_output_fault_i, supply_ok_i};
            sync2_ff <= sync1_ff;
        end
    end

    assign sup_s = sync2_ff[FLAG_SUP];
    assign uv_s = sync2_ff[FLAG_LOW];
    assign ov_s = sync2_ff[FLAG_HIGH];
    assign ss_done = (ss_ref_o == REF_FULL) && (step_ff == STEP_W'(SS_STEP - 1));
    // guard is armed once threshold setting is over
    assign guard_on = (state_ff != BFP_LOCKOUT) && (state_ff != BFP_OCSET);

    bfp_pwm #(
        .PERIOD(SAW_PERIOD),
        .DUTY_MAX(DUTY_MAX_CNT)
    ) u_pwm (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .level_i(error_amp_i),
        .pwm_o(pwm),
        .tick_o(sw_tick)
    );

    // sequencing state and its timers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= BFP_LOCKOUT;
            tmr_ff <= '0;
            sw_cnt_ff <= '0;
        end else if (!sup_s) begin
            state_ff <= BFP_LOCKOUT;
            tmr_ff <= '0;
            sw_cnt_ff <= '0;
        end else begin
            case (state_ff)
                BFP_LOCKOUT: begin
                    state_ff <= BFP_OCSET;
                    tmr_ff <= '0;
                end
                BFP_OCSET: begin
                    // fixed at the least time of the window
                    if (tmr_ff == TMR_W'(OCSET_CYCLES_P - 1)) begin
                        state_ff <= BFP_SOFTSTART;
                        tmr_ff <= '0;
                    end else begin
                        tmr_ff <= tmr_ff + TMR_W'(1);
                    end
                end
                BFP_SOFTSTART: begin
                    // low output flag not looked at here
                    if (ss_done) begin
                        state_ff <= BFP_RUN;
                    end
                end
                BFP_RUN: begin
                    if (uv_s) begin
                        state_ff <= BFP_FAULT_OFF;
                        sw_cnt_ff <= '0;
                    end
                end
                BFP_FAULT_OFF: begin
                    // counted in switching cycles; returns to soft-start each time
                    if (sw_tick) begin
                        if (sw_cnt_ff == SW_CNT_W'(FAULT_WAIT_P - 1)) begin
                            state_ff <= BFP_SOFTSTART;
                            sw_cnt_ff <= '0;
                        end else begin
                            sw_cnt_ff <= sw_cnt_ff + SW_CNT_W'(1);
                        end
                    end
                end
                default: begin
                    state_ff <= BFP_LOCKOUT;
                end
            endcase
        end
    end

    // reference ramp; a step counter avoids a divider
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ss_ref_o <= REF_ZERO;
            step_ff <= '0;
        end else if (state_ff == BFP_SOFTSTART) begin
            if (step_ff == STEP_W'(SS_STEP - 1)) begin
                step_ff <= '0;
                if (ss_ref_o != REF_FULL) begin
                    ss_ref_o <= ss_ref_o + REF_W'(1);
                end
            end else begin
                step_ff <= step_ff + STEP_W'(1);
            end
        end else if (state_ff == BFP_RUN) begin
            ss_ref_o <= REF_FULL;
            step_ff <= '0;
        end else begin
            ss_ref_o <= REF_ZERO;
            step_ff <= '0;
        end
    end

    // low side held off in soft-start until high side first switches, unless the high output override forces it on
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hs_seen_ff <= 1'b0;
        end else if (state_ff == BFP_SOFTSTART) begin
            hs_seen_ff <= hs_seen_ff | pwm;
        end else if (state_ff != BFP_RUN) begin
            hs_seen_ff <= 1'b0;
        end
    end

    // gate source selection, high output override last so it wins
    always_comb begin
        nxt_hs = 1'b0;
        nxt_ls = 1'b0;
        case (state_ff)
            BFP_SOFTSTART: begin
                nxt_hs = pwm;
                nxt_ls = !pwm && hs_seen_ff;
            end
            BFP_RUN: begin
                nxt_hs = pwm;
                nxt_ls = !pwm;
            end
            default: begin
                nxt_hs = 1'b0;
                nxt_ls = 1'b0;
            end
        endcase
        if (ov_s && guard_on) begin
            nxt_hs = 1'b0;
            nxt_ls = 1'b1;
        end
    end

    // registered gates; both come from one decision so never overlap
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            high_side_gate_o <= 1'b0;
            low_side_gate_o <= 1'b0;
            soft_start_o <= 1'b0;
            fault_off_o <= 1'b0;
        end else begin
            high_side_gate_o <= nxt_hs;
            low_side_gate_o <= nxt_ls;
            soft_start_o <= (state_ff == BFP_SOFTSTART);
            fault_off_o <= (state_ff == BFP_FAULT_OFF);
        end
    end

    sequence s_ov_held;
        (ov_s && guard_on && sup_s)[*4];
    endsequence

    sequence s_gates_forced;
        (!high_side_gate_o && low_side_gate_o);
    endsequence

    property p_uv_off;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_ff == BFP_RUN && uv_s && sup_s) |-> ##2 (!high_side_gate_o && (!low_side_gate_o || $past(ov_s)));
    endproperty
    AST_UV_GATES_OFF: assert property (p_uv_off) else $error("gates not off after low output");

    property p_wait;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_ff == BFP_SOFTSTART && $past(state_ff) == BFP_FAULT_OFF)
            |-> ($past(sw_cnt_ff) == SW_CNT_W'(FAULT_WAIT_P - 1) && $past(sw_tick));
    endproperty
    AST_FAULT_WAIT: assert property (p_wait) else $error("restart before fault wait ended");

    property p_hiccup;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_ff == BFP_FAULT_OFF) |=> (state_ff inside {BFP_FAULT_OFF, BFP_SOFTSTART, BFP_LOCKOUT});
    endproperty
    AST_HICCUP_LOOP: assert property (p_hiccup) else $error("fault off left to wrong state");

    property p_uv_mask;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_ff == BFP_SOFTSTART && uv_s && sup_s && !ss_done) |=> (state_ff == BFP_SOFTSTART);
    endproperty
    AST_UV_MASKED: assert property (p_uv_mask) else $error("low output acted in soft-start");

    property p_ov;
        @(posedge clk_i) disable iff (!nrst_i)
        (ov_s && guard_on) |=> s_gates_forced;
    endproperty
    AST_OV_FORCE: assert property (p_ov) else $error("high output override missing");

    property p_ov_release;
        @(posedge clk_i) disable iff (!nrst_i)
        (!ov_s && state_ff == BFP_RUN) |=> (high_side_gate_o == $past(pwm) && low_side_gate_o == !$past(pwm));
    endproperty
    AST_OV_RELEASE: assert property (p_ov_release) else $error("override outlived condition");

    property p_float;
        @(posedge clk_i) disable iff (!nrst_i)
        s_ov_held |=> s_gates_forced ##0 !high_side_gate_o;
    endproperty
    AST_FLOAT_HOLD: assert property (p_float) else $error("low side not held on");

    property p_lockout;
        @(posedge clk_i) disable iff (!nrst_i)
        (!sup_s) |=> (state_ff == BFP_LOCKOUT) ##1 (!high_side_gate_o && !low_side_gate_o);
    endproperty
    AST_LOCKOUT: assert property (p_lockout) else $error("gates active under lockout");

    property p_ss_entry;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_ff == BFP_SOFTSTART && $past(state_ff) == BFP_OCSET)
            |-> ($past(tmr_ff) == TMR_W'(OCSET_CYCLES_P - 1) && $past(sup_s));
    endproperty
    AST_SS_ENTRY: assert property (p_ss_entry) else $error("soft-start began early");

    AST_NO_OVERLAP: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !(high_side_gate_o && low_side_gate_o)) else $error("both gates on");
endmodule

//--- tb/bfp_plant.sv
/*
 * Behavioural power stage and feedback divider facing the sequencer.
 * Assumes the bench selects a plant condition through mode_i.
 */
`timescale 1ns/1ps
module bfp_plant (
    // gate enables from the sequencer
    input wire logic high_side_gate_i,
    input wire logic low_side_gate_i,
    // 0 regulating, 1 feedback open, 2 output collapsed, 3 overshoot
    input wire logic [1:0] mode_i,
    // comparator flags seen by the sequencer
    output logic low_output_fault_o,
    output logic high_output_fault_o
);
    // gates are not modelled into a voltage: faults come from mode only
    always_comb begin
        low_output_fault_o = (mode_i == 2'h2);
        // open feedback pin is pulled above the high threshold by its bias
        high_output_fault_o = (mode_i == 2'h1) || (mode_i == 2'h3);
    end
endmodule

//--- tb/testbench.sv
/*
 * Self-checking bench for the fault protection sequencer.
 * Assumes short soft-start, threshold setting and fault wait parameters;
 * the full 2048 wrap wait would not fit in a run of sensible length.
 */
`timescale 1ns/1ps
module testbench;
    import bfp_pkg::*;
    localparam int SS_P = 2550;
    localparam int OC_P = 50;
    localparam int FW_P = 4;
    logic clk_i, nrst_i, supply_ok_i, low_f, high_f, hs, ls, ss_on, f_off;
    logic [SAW_W-1:0] error_amp_i;
    logic [1:0] mode;
    logic [REF_W-1:0] ss_ref;
    int fails, num_checks, n, nh, nl, nf;
    int lv[5] = '{0, 333, 532, 533, 1023};

    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    bfp_sequencer #(.SS_CYCLES_P(SS_P), .OCSET_CYCLES_P(OC_P), .FAULT_WAIT_P(FW_P)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .supply_ok_i(supply_ok_i),
        .low_output_fault_i(low_f), .high_output_fault_i(high_f), .error_amp_i(error_amp_i),
        .high_side_gate_o(hs), .low_side_gate_o(ls), .ss_ref_o(ss_ref),
        .soft_start_o(ss_on), .fault_off_o(f_off));
    bfp_plant plant (.high_side_gate_i(hs), .low_side_gate_i(ls), .mode_i(mode),
        .low_output_fault_o(low_f), .high_output_fault_o(high_f));

    // shoot-through watch over the whole run
    always @(negedge clk_i) begin
        if (hs === 1'b1 && ls === 1'b1) begin
            fails++;
            $display("wrong value at %0t: both gates on", $time);
        end
    end

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task automatic chk_word(input logic [REF_W-1:0] got, input logic [REF_W-1:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task automatic chk_range(input int got, input int lo, input int hi, input string m);
        num_checks++;
        if (got < lo || got > hi) begin
            fails++;
            $display("wrong value at %0t: %s got %0d", $time, m, got);
        end
    endtask

    // inputs move 1 ns after the edge, outputs are read there too
    task automatic step(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask

    function automatic logic sel(input int w);
        case (w)
            0: return ss_on;
            1: return f_off;
            default: return hs;
        endcase
    endfunction

    // bounded wait; running out ends the run as a failure
    task automatic wait_for(input int w, input logic v, input int lim, output int c);
        c = 0;
        while (sel(w) !== v) begin
            if (c >= lim) begin
                fails++;
                $display("wrong value at %0t: wait %0d timed out", $time, w);
                wrap_up();
            end
            step(1);
            c++;
        end
    endtask

    task automatic count_gates(input int c, output int h, output int l, output int f);
        h = 0;
        l = 0;
        f = 0;
        repeat (c) begin
            step(1);
            h += (hs === 1'b1);
            l += (ls === 1'b1);
            f += (f_off === 1'b1);
        end
    endtask

    task automatic restart(input logic sup);
        nrst_i = 1'b0;
        supply_ok_i = sup;
        step(4);
        nrst_i = 1'b1;
    endtask

    task automatic go_run();
        mode = 2'h0;
        error_amp_i = 10'h14D;
        restart(1'b1);
        wait_for(0, 1'b1, 200, n);
        wait_for(0, 1'b0, SS_P + 200, n);
    endtask

    task automatic t_lockout();
        restart(1'b0);
        count_gates(100, nh, nl, nf);
        chk_range(nh + nl, 0, 0, "gates in lockout");
        chk_word(ss_ref, REF_ZERO, "ref in lockout");
        supply_ok_i = 1'b1;
        wait_for(0, 1'b1, 200, n);
        chk_range(n, OC_P, OC_P + 8, "setting phase length");
        $display("test lockout done");
    endtask

    task automatic t_softstart();
        logic [REF_W-1:0] prev;
        int bad;
        prev = REF_ZERO;
        bad = 0;
        n = 0;
        mode = 2'h2;
        while (ss_on === 1'b1 && n < SS_P + 200) begin
            if (n == 1000) mode = 2'h3;
            if (n == 1020) begin
                chk_bit(hs, 1'b0, "high side under overshoot");
                chk_bit(ls, 1'b1, "low side under overshoot");
                mode = 2'h0;
            end
            bad += ((ss_ref < prev) !== 1'b0) || (f_off !== 1'b0);
            prev = ss_ref;
            step(1);
            n++;
        end
        chk_range(bad, 0, 0, "ramp fell or fault taken");
        chk_range(n, SS_P - 10, SS_P + 40, "ramp length");
        chk_word(ss_ref, REF_FULL, "ref after ramp");
        $display("test softstart done");
    endtask

    task automatic t_pwm();
        go_run();
        foreach (lv[i]) begin
            error_amp_i = lv[i][SAW_W-1:0];
            step(2 * SAW_PERIOD);
            count_gates(SAW_PERIOD, nh, nl, nf);
            n = (lv[i] < DUTY_MAX_CNT) ? lv[i] : DUTY_MAX_CNT;
            chk_range(nh, n, n, "high side on time");
            chk_range(nl, SAW_PERIOD - n, SAW_PERIOD - n, "low side on time");
        end
        $display("test pwm done");
    endtask

    task automatic t_overvolt();
        error_amp_i = 10'h3FF;
        mode = 2'h3;
        step(6);
        count_gates(300, nh, nl, nf);
        chk_range(nh, 0, 0, "high side during overshoot");
        chk_range(nl, 300, 300, "low side during overshoot");
        mode = 2'h0;
        wait_for(2, 1'b1, SAW_PERIOD + 10, n);
        $display("test overvolt done");
    endtask

    task automatic t_floating();
        mode = 2'h1;
        step(4); // flag sync and gate register latency
        count_gates(3 * SAW_PERIOD, nh, nl, nf);
        chk_range(nh, 0, 0, "high side with open feedback");
        chk_range(nl, 3 * SAW_PERIOD - 6, 3 * SAW_PERIOD, "low side with open feedback");
        restart(1'b1);
        wait_for(0, 1'b1, 200, n);
        step(20);
        chk_bit(ls, 1'b1, "low side held in soft-start");
        $display("test floating done");
    endtask

    task automatic t_undervolt();
        go_run();
        mode = 2'h2;
        wait_for(1, 1'b1, 8, n);
        // fault held through the restart so a second round must follow
        count_gates((FW_P - 1) * SAW_PERIOD, nh, nl, nf);
        chk_range(nh + nl, 0, 0, "gates during fault wait");
        chk_range(nf, (FW_P - 1) * SAW_PERIOD, (FW_P - 1) * SAW_PERIOD, "fault wait held");
        wait_for(0, 1'b1, SAW_PERIOD + 10, n);
        chk_range(n, 1, SAW_PERIOD, "fault wait length");
        wait_for(0, 1'b0, SS_P + 200, n);
        chk_range(n, SS_P - 10, SS_P + 40, "restart ramp length");
        wait_for(1, 1'b1, 8, n);
        chk_range(n, 1, 3, "fault taken again after ramp");
        $display("test undervolt done");
    endtask

    task automatic t_supply_drop();
        go_run();
        supply_ok_i = 1'b0;
        step(5);
        chk_bit(hs | ls, 1'b0, "gates after supply loss");
        chk_word(ss_ref, REF_ZERO, "ref after supply loss");
        supply_ok_i = 1'b1;
        wait_for(0, 1'b1, 200, n);
        chk_range(n, OC_P, OC_P + 8, "setting phase repeats");
        $display("test supply drop done");
    endtask

    // main sequence
    initial begin
        fails = 0;
        num_checks = 0;
        mode = 2'h0;
        error_amp_i = 10'h14D;
        t_lockout();
        t_softstart();
        t_pwm();
        t_overvolt();
        t_floating();
        t_undervolt();
        t_supply_drop();
        wrap_up();
    end
endmodule
